// File: verilog/asow_defs.svh
`ifndef ASOW_DEFS_SVH
`define ASOW_DEFS_SVH

// Serial timing
`define ASOW_CLK_NS          10
`define ASOW_SCLK_NS         160
`define ASOW_HALF_CYC        (`ASOW_SCLK_NS / `ASOW_CLK_NS / 2)
`define ASOW_WORD_BITS       6'h20
`define ASOW_DIV_CYC         4

// Command opcodes, bits 31:27 of the command word; write sub-codes, bits 26:25
`define ASOW_OP_CLR_HW       5'h18
`define ASOW_OP_RD_HW        5'h19
`define ASOW_OP_RD_BYTE      5'h09
`define ASOW_OP_WR           5'h1A
`define ASOW_OP_SET_HW       5'h1B
`define ASOW_WR_BOTH         2'h0
`define ASOW_WR_HIGH         2'h1
`define ASOW_WR_LOW          2'h2

// Device register word indexes (byte address bits 4:2)
`define ASOW_IX_CHAIN_ID     3'h0
`define ASOW_IX_IN_CTL       3'h2
`define ASOW_IX_OUT_CTL      3'h3
`define ASOW_IX_FMT_CTL      3'h4
`define ASOW_IX_LAST         3'h4

// Writable bit masks per register
`define ASOW_MASK_CHAIN_ID   32'h000F0000
`define ASOW_MASK_IN_CTL     32'h00000003
`define ASOW_MASK_OUT_CTL    32'h000000FF
`define ASOW_MASK_FMT_CTL    32'h00001F07
`define ASOW_MASK_NONE       32'h00000000

// Fields
`define ASOW_F_CHAIN_ID      19:16
`define ASOW_F_WPP           1:0
`define ASOW_F_RPP           1:0
`define ASOW_F_SSYNC_INT     6
`define ASOW_F_OPC           7:0
`define ASOW_F_FPS           2:0
`define ASOW_F_FPS_ON        2
`define ASOW_F_FPS_SEL       1:0
`define ASOW_F_INCL          12:8

// Fixed test patterns
`define ASOW_PAT_0           32'h00000000
`define ASOW_PAT_1           32'hFFFFFFFF
`define ASOW_PAT_2           32'hAAAAAAAA
`define ASOW_PAT_3           32'hCCCCCCCC

// Output word layout
`define ASOW_TAIL_W          18
`define ASOW_RES_W           14

// Host register map (address bits 1:0)
`define ASOW_H_TX            2'h0
`define ASOW_H_CFG           2'h1
`define ASOW_H_RX            2'h2
`define ASOW_H_STAT          2'h3
`define ASOW_H_F_BITS        5:0
`define ASOW_H_F_PROTO       9:8
`define ASOW_H_CFG_RST       32'h00000020

`endif

// File: verilog/asow_pkg.sv
package asow_pkg;
  typedef enum logic [1:0] {ASOW_RD_CONV, ASOW_RD_HALF,
                            ASOW_RD_BYTE} asow_rd_t;
  typedef enum logic [2:0] {ASOW_H_IDLE, ASOW_H_LEAD, ASOW_H_CLK,
                            ASOW_H_TRAIL, ASOW_H_GAP} asow_hst_t;
endpackage : asow_pkg

// File: verilog/asow_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asow_link_if;
  logic convert_and_select_n;
  logic serial_clock;
  logic serial_in;
  logic serial_out_lanes;
  logic ready_strobe_clock;
  modport device (input convert_and_select_n, input serial_clock,
                  input serial_in, output serial_out_lanes,
                  output ready_strobe_clock);
  modport host (output convert_and_select_n, output serial_clock,
                output serial_in, input serial_out_lanes,
                input ready_strobe_clock);
endinterface : asow_link_if
`default_nettype wire

// File: verilog/asow_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "asow_defs.svh"
module asow_device #(
  parameter int DIV_CYC = `ASOW_DIV_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  asow_link_if.device                 link,
  input  wire logic [`ASOW_RES_W-1:0] conv_result,
  input  wire logic [1:0]             supply_alarm,
  input  wire logic [1:0]             input_alarm,
  input  wire logic [3:0]             range_flags,
  output logic      [1:0]             active_protocol,
  output logic                        command_done
);
  function automatic logic [`ASOW_TAIL_W-1:0] asow_tail(
    input logic [4:0] en,
    input logic [3:0] id,
    input logic [1:0] sa,
    input logic [1:0] ia,
    input logic [3:0] rg,
    input logic [1:0] rpar
  );
    logic [`ASOW_TAIL_W-1:0] acc;
    logic [4:0]              n;
    acc = '0;
    n   = 5'h00;
    acc = en[4] ? {acc[13:0], id} : acc;
    n   = en[4] ? n + 5'h04 : n;
    acc = en[3] ? {acc[15:0], sa} : acc;
    n   = en[3] ? n + 5'h02 : n;
    acc = en[2] ? {acc[15:0], ia} : acc;
    n   = en[2] ? n + 5'h02 : n;
    acc = en[1] ? {acc[13:0], rg} : acc;
    n   = en[1] ? n + 5'h04 : n;
    acc = en[0] ? {acc[15:0], rpar} : acc;
    n   = en[0] ? n + 5'h02 : n;
    // Left-align so groups follow the result with no gaps
    asow_tail = acc << (5'h12 - n);
  endfunction : asow_tail
  function automatic logic [31:0] asow_mask(input logic [2:0] ix);
    case (ix)
      `ASOW_IX_CHAIN_ID: asow_mask = `ASOW_MASK_CHAIN_ID;
      `ASOW_IX_IN_CTL:   asow_mask = `ASOW_MASK_IN_CTL;
      `ASOW_IX_OUT_CTL:  asow_mask = `ASOW_MASK_OUT_CTL;
      `ASOW_IX_FMT_CTL:  asow_mask = `ASOW_MASK_FMT_CTL;
      default:           asow_mask = `ASOW_MASK_NONE;
    endcase
  endfunction : asow_mask
  // Link pins cross into clk through two flops; stage 3 is for edges only
  logic [2:0]  cs_q;
  logic [2:0]  ck_q;
  logic [1:0]  di_q;
  logic [31:0] regs_r [0:4];
  logic [31:0] in_sh_r;
  logic [31:0] out_sh_r;
  logic [5:0]  cnt_r;
  logic        sdo_r;
  logic        first_r;
  logic        rvs_r;
  logic        done_r;
  logic [8:0]  rd_addr_r;
  logic [7:0]  div_r;
  asow_pkg::asow_rd_t rd_kind_r;
  wire cs_fall  = cs_q[2] & ~cs_q[1];
  wire cs_rise  = ~cs_q[2] & cs_q[1];
  wire in_frame = ~cs_q[1];
  wire ck_rise  = ~ck_q[2] & ck_q[1];
  wire ck_fall  = ck_q[2] & ~ck_q[1];
  wire [1:0] wpp      = regs_r[`ASOW_IX_IN_CTL][`ASOW_F_WPP];
  wire [7:0] opc      = regs_r[`ASOW_IX_OUT_CTL][`ASOW_F_OPC];
  wire [2:0] fps      = regs_r[`ASOW_IX_FMT_CTL][`ASOW_F_FPS];
  wire [4:0] incl     = regs_r[`ASOW_IX_FMT_CTL][`ASOW_F_INCL];
  wire [3:0] chain_id = regs_r[`ASOW_IX_CHAIN_ID][`ASOW_F_CHAIN_ID];
  // Modes 00 and 11 capture on rising edges, others on falling
  wire cap_rise = ~(wpp[1] ^ wpp[0]);
  wire cpha     = wpp[0];
  wire src_mode = opc[`ASOW_F_RPP] != 2'h0;
  wire src_int  = src_mode & opc[`ASOW_F_SSYNC_INT];
  wire tick     = div_r == 8'(DIV_CYC - 1);
  wire cap_ev   = in_frame & (cap_rise ? ck_rise : ck_fall);
  wire ext_lau  = in_frame & (cap_rise ? ck_fall : ck_rise);
  wire int_lau  = in_frame & tick & rvs_r;
  wire lau_ev   = src_int ? int_lau : ext_lau;
  // Past 32 bits, with opc zero, the input stream refills the output for chaining
  wire fill_bit = (opc == 8'h00) ? in_sh_r[0] : 1'b0;
  // Command decode
  wire [4:0]  op      = in_sh_r[31:27];
  wire [1:0]  sub     = in_sh_r[26:25];
  wire [8:0]  addr    = in_sh_r[24:16];
  wire [15:0] dat     = in_sh_r[15:0];
  wire [2:0]  widx    = addr[4:2];
  wire        a_ok    = (addr[8:5] == 4'h0) && (widx <= `ASOW_IX_LAST);
  wire        full    = cnt_r >= `ASOW_WORD_BITS;
  wire        exec    = cs_rise & full & a_ok;
  wire [31:0] old_w   = regs_r[widx];
  // Halfword commands ignore address bit 0
  wire [15:0] old16   = addr[1] ? old_w[31:16] : old_w[15:0];
  wire        is_wr   = (op == `ASOW_OP_WR) || (op == `ASOW_OP_SET_HW)
                        || (op == `ASOW_OP_CLR_HW);
  wire [15:0] wr16    = (sub == `ASOW_WR_BOTH) ? dat :
                        (sub == `ASOW_WR_HIGH) ? {dat[15:8], old16[7:0]} :
                        (sub == `ASOW_WR_LOW)  ? {old16[15:8], dat[7:0]} :
                        old16;
  wire [15:0] new16   = (op == `ASOW_OP_SET_HW) ? (old16 | dat) :
                        (op == `ASOW_OP_CLR_HW) ? (old16 & ~dat) : wr16;
  wire [31:0] new_w   = addr[1] ? {new16, old_w[15:0]}
                                : {old_w[31:16], new16};
  wire        rd_hw   = full & a_ok & (op == `ASOW_OP_RD_HW);
  wire        rd_by   = full & a_ok & (op == `ASOW_OP_RD_BYTE);
  // Short frames act as no-ops and fall back to the result
  wire asow_pkg::asow_rd_t rd_kind_nxt =
    rd_hw ? asow_pkg::ASOW_RD_HALF :
    rd_by ? asow_pkg::ASOW_RD_BYTE : asow_pkg::ASOW_RD_CONV;
  // Output word assembly
  wire [31:0] rsel    = regs_r[rd_addr_r[4:2]];
  wire [15:0] rd16    = rd_addr_r[1] ? rsel[31:16] : rsel[15:0];
  wire [7:0]  rd8     = rd_addr_r[0] ? rd16[15:8] : rd16[7:0];
  wire [31:0] pattern = (fps[`ASOW_F_FPS_SEL] == 2'h0) ? `ASOW_PAT_0 :
                        (fps[`ASOW_F_FPS_SEL] == 2'h1) ? `ASOW_PAT_1 :
                        (fps[`ASOW_F_FPS_SEL] == 2'h2) ? `ASOW_PAT_2 :
                        `ASOW_PAT_3;
  wire [11:0] flags   = {chain_id, supply_alarm, input_alarm, range_flags};
  wire [1:0]  par     = {^conv_result, ^{conv_result, flags}};
  wire [`ASOW_TAIL_W-1:0] tail =
    asow_tail(incl, chain_id, supply_alarm, input_alarm, range_flags, par);
  wire [31:0] conv_w  = {conv_result, tail};
  wire [31:0] word    =
    fps[`ASOW_F_FPS_ON] ? pattern :
    (rd_kind_r == asow_pkg::ASOW_RD_HALF) ? {rd16, 16'h0000} :
    (rd_kind_r == asow_pkg::ASOW_RD_BYTE) ? {rd8, 24'h000000} :
    conv_w;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_q <= 3'h7;
      ck_q <= 3'h0;
      di_q <= 2'h0;
    end
    else
    begin
      cs_q <= {cs_q[1:0], link.convert_and_select_n};
      ck_q <= {ck_q[1:0], link.serial_clock};
      di_q <= {di_q[0], link.serial_in};
    end
  end
  // Register file written only by complete commands
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i <= 4; i++)
        regs_r[i] <= 32'h00000000;
    end
    else if (exec && is_wr)
      regs_r[widx] <= new_w & asow_mask(widx);
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      in_sh_r   <= 32'h00000000;
      cnt_r     <= 6'h00;
      rd_kind_r <= asow_pkg::ASOW_RD_CONV;
      rd_addr_r <= 9'h000;
      done_r    <= 1'b0;
    end
    else
    begin
      done_r <= exec;
      if (cs_fall)
        cnt_r <= 6'h00;
      else if (cap_ev)
      begin
        in_sh_r <= {in_sh_r[30:0], di_q[1]};
        // Saturate so long frames stay flagged as full
        if (cnt_r != 6'h3F)
          cnt_r <= cnt_r + 6'h01;
      end
      if (cs_rise)
      begin
        rd_kind_r <= rd_kind_nxt;
        rd_addr_r <= addr;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      div_r <= 8'h00;
    else if (tick || !in_frame)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_sh_r <= 32'h00000000;
      sdo_r    <= 1'b0;
      first_r  <= 1'b0;
      rvs_r    <= 1'b0;
    end
    else
    begin
      if (!in_frame || !src_mode)
        rvs_r <= 1'b0;
      else if (src_int)
        rvs_r <= tick ? ~rvs_r : rvs_r;
      else
        rvs_r <= ck_q[1];
      if (cs_fall)
      begin
        out_sh_r <= word;
        first_r  <= cpha & ~src_int;
        sdo_r    <= (cpha & ~src_int) ? 1'b0 : word[31];
      end
      else if (lau_ev)
      begin
        if (first_r)
        begin
          first_r <= 1'b0;
          sdo_r   <= out_sh_r[31];
        end
        else
        begin
          out_sh_r <= {out_sh_r[30:0], fill_bit};
          sdo_r    <= out_sh_r[30];
        end
      end
    end
  end

  assign link.serial_out_lanes   = sdo_r;
  assign link.ready_strobe_clock = rvs_r;
  assign active_protocol         = regs_r[`ASOW_IX_IN_CTL][`ASOW_F_WPP];
  assign command_done            = done_r;

endmodule : asow_device
`default_nettype wire

// File: verilog/asow_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "asow_defs.svh"
module asow_host #(
  parameter int HALF_CYC = `ASOW_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  asow_link_if.host        link,
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);

  asow_pkg::asow_hst_t st_r;
  logic [31:0] cfg_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic [7:0]  hcnt_r;
  logic [6:0]  edge_r;
  logic [1:0]  proto_r;
  logic [1:0]  so_q;
  logic        cs_r;
  logic        ck_r;
  logic        sdi_r;
  logic        first_r;
  logic        done_r;
  logic [31:0] rdata_r;

  wire idle     = st_r == asow_pkg::ASOW_H_IDLE;
  wire start    = wr && (addr == `ASOW_H_TX) && idle;
  wire [1:0] np = cfg_r[`ASOW_H_F_PROTO];
  wire tick     = hcnt_r == 8'(HALF_CYC - 1);
  wire [6:0] nedge = {cfg_r[`ASOW_H_F_BITS], 1'b0};
  wire cap_rise = ~(proto_r[1] ^ proto_r[0]);
  // The edge about to be made is rising when the clock is low now
  wire is_cap   = (~ck_r) == cap_rise;
  wire clk_ev   = (st_r == asow_pkg::ASOW_H_CLK) && tick;
  wire last     = clk_ev && (edge_r == nedge - 7'h01);
  wire rd_rx    = rd && (addr == `ASOW_H_RX);
  wire [31:0] rd_mux = (addr == `ASOW_H_TX)  ? tx_r :
                       (addr == `ASOW_H_CFG) ? cfg_r :
                       (addr == `ASOW_H_RX)  ? rx_r :
                       {30'h00000000, done_r, ~idle};

  always_ff @(posedge clk)
  begin
    if (reset)
      so_q <= 2'h0;
    else
      so_q <= {so_q[0], link.serial_out_lanes};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_r   <= `ASOW_H_CFG_RST;
      rdata_r <= 32'h00000000;
      done_r  <= 1'b0;
    end
    else
    begin
      if (wr && (addr == `ASOW_H_CFG))
        cfg_r <= wdata;
      if (rd)
        rdata_r <= rd_mux;
      // Frame end beats a read clear in the same cycle
      if ((st_r == asow_pkg::ASOW_H_GAP) && tick)
        done_r <= 1'b1;
      else if (rd_rx)
        done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || idle || tick)
      hcnt_r <= 8'h00;
    else
      hcnt_r <= hcnt_r + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r    <= asow_pkg::ASOW_H_IDLE;
      proto_r <= 2'h0;
      cs_r    <= 1'b1;
      ck_r    <= 1'b0;
      sdi_r   <= 1'b0;
      first_r <= 1'b0;
      tx_r    <= 32'h00000000;
      rx_r    <= 32'h00000000;
      edge_r  <= 7'h00;
    end
    else
    begin
      case (st_r)
        asow_pkg::ASOW_H_IDLE:
        begin
          if (start)
          begin
            // Software must switch protocol with a frame in the current mode, then update CFG
            proto_r <= np;
            ck_r    <= np[1];
            cs_r    <= 1'b0;
            tx_r    <= wdata;
            first_r <= np[0];
            sdi_r   <= np[0] ? 1'b0 : wdata[31];
            edge_r  <= 7'h00;
            st_r    <= asow_pkg::ASOW_H_LEAD;
          end
          else
            ck_r <= proto_r[1];
        end
        asow_pkg::ASOW_H_LEAD:
          if (tick)
            st_r <= asow_pkg::ASOW_H_CLK;
        asow_pkg::ASOW_H_CLK:
        begin
          if (tick)
          begin
            ck_r   <= ~ck_r;
            edge_r <= edge_r + 7'h01;
            if (is_cap)
              rx_r <= {rx_r[30:0], so_q[1]};
            else if (first_r)
            begin
              first_r <= 1'b0;
              sdi_r   <= tx_r[31];
            end
            else
            begin
              tx_r  <= {tx_r[30:0], 1'b0};
              sdi_r <= tx_r[30];
            end
          end
          // Frame length comes from CFG; writes need 32 or more
          if (last)
            st_r <= asow_pkg::ASOW_H_TRAIL;
        end
        asow_pkg::ASOW_H_TRAIL:
          if (tick)
          begin
            cs_r <= 1'b1;
            st_r <= asow_pkg::ASOW_H_GAP;
          end
        asow_pkg::ASOW_H_GAP:
          if (tick)
            st_r <= asow_pkg::ASOW_H_IDLE;
        default:
          st_r <= asow_pkg::ASOW_H_IDLE;
      endcase
    end
  end

  assign link.convert_and_select_n = cs_r;
  assign link.serial_clock         = ck_r;
  assign link.serial_in            = sdi_r;
  assign rdata                     = rdata_r;

endmodule : asow_host
`default_nettype wire

// File: test/asow_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asow_link_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic convert_and_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out_lanes,
  input wire logic ready_strobe_clock
);
  logic       cs_q_r;
  logic       sclk_q_r;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  wire        pin_chg = (cs_q_r != convert_and_select_n)
                        || (sclk_q_r != serial_clock);

  // Cycles since either link control pin last moved, saturating
  assign quiet_nxt = pin_chg ? 4'h0 :
                     (quiet_r == 4'hF) ? 4'hF : quiet_r + 4'h1;

  always_ff @(posedge clk)
  begin
    cs_q_r   <= convert_and_select_n;
    sclk_q_r <= serial_clock;
    quiet_r  <= reset ? 4'h0 : quiet_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_rst_dev;
    $fell(reset) |-> !serial_out_lanes && !ready_strobe_clock;
  endproperty
  a_rst_dev: assert property (p_rst_dev)
    else $error("device outputs not idle after reset");
  property p_rst_host;
    $fell(reset) |-> convert_and_select_n && !serial_clock && !serial_in;
  endproperty
  a_rst_host: assert property (p_rst_host)
    else $error("host link pins not idle after reset");
  property p_rsv_low;
    !convert_and_select_n |-> !ready_strobe_clock;
  endproperty
  a_rsv_low: assert property (p_rsv_low)
    else $error("ready strobe high inside frame");
  // Launch lags the pin edge by the sync chain, so allow 7 cycles
  property p_out_stable;
    !convert_and_select_n && quiet_r >= 4'h7 |-> $stable(serial_out_lanes);
  endproperty
  a_out_stable: assert property (p_out_stable)
    else $error("data changed away from a launch edge");
  property p_msb;
    $fell(convert_and_select_n) |-> ##8 $stable(serial_out_lanes)[*4];
  endproperty
  a_msb: assert property (p_msb)
    else $error("leading bit not steady before first clock edge");
  property p_sclk_half;
    $changed(serial_clock) |=> $stable(serial_clock)[*8];
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period too short");
  property p_cs_rise;
    $rose(convert_and_select_n) |-> quiet_r >= 4'h8;
  endproperty
  a_cs_rise: assert property (p_cs_rise)
    else $error("select raised too soon after clock edge");
  property p_cs_gap;
    $rose(convert_and_select_n) |=> convert_and_select_n[*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("gap between frames too short");

  c_frame: cover property ($fell(convert_and_select_n));
  c_data:  cover property (!convert_and_select_n && $rose(serial_out_lanes));
  c_end:   cover property ($rose(convert_and_select_n));
endmodule : asow_link_properties
`default_nettype wire

// File: test/adc_serial_output_word_and_protocol_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module adc_serial_output_word_and_protocol_bench;
  logic        clk       = 1'b0;
  logic        reset     = 1'b1;
  logic [1:0]  addr      = 2'h0;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [13:0] res       = 14'h2A5C;
  logic [1:0]  sa        = 2'h2;
  logic [1:0]  ia        = 2'h1;
  logic [3:0]  rg        = 4'h9;
  logic [31:0] rdata;
  logic [1:0]  proto;
  logic        done;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          dn        = 0;

  asow_link_if asow_link_if_i ();
  asow_host #(.HALF_CYC(12)) asow_host_i (.clk(clk), .reset(reset),
    .link(asow_link_if_i.host), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  asow_device asow_device_i (.clk(clk), .reset(reset),
    .link(asow_link_if_i.device), .conv_result(res), .supply_alarm(sa),
    .input_alarm(ia), .range_flags(rg), .active_protocol(proto),
    .command_done(done));
  asow_link_properties asow_link_properties_i (.clk(clk), .reset(reset),
    .convert_and_select_n(asow_link_if_i.convert_and_select_n),
    .serial_clock(asow_link_if_i.serial_clock),
    .serial_in(asow_link_if_i.serial_in),
    .serial_out_lanes(asow_link_if_i.serial_out_lanes),
    .ready_strobe_clock(asow_link_if_i.ready_strobe_clock));

  always #5 clk = ~clk;

  task automatic test_done;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cyc++;
    if (done === 1'b1) dn++;
    if (cyc == 60000)
    begin
      err_count++;
      test_done();
    end
  end

  // One strobe cycle; read data sampled in the cycle after it
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    wr <= w; rd <= !w; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1;
  endtask : bus

  // Wait for done with busy clear, else the next TX write is dropped
  task automatic frame(input logic [31:0] cmd, output logic [31:0] got);
    int n;
    n = 0;
    bus(1'b1, 2'h0, cmd);
    bus(1'b0, 2'h3, 32'h0);
    while (rdata[1:0] !== 2'b10 && n < 1000)
    begin
      bus(1'b0, 2'h3, 32'h0);
      n++;
    end
    `CHK("frame end", 1'b1, n < 1000)
    bus(1'b0, 2'h2, 32'h0);
    got = rdata;
  endtask : frame

  task automatic dwr(input logic [8:0] a, input logic [15:0] d);
    logic [31:0] g;
    int          c;
    c = dn;
    frame({5'h1A, 2'h0, a, d}, g);
    `CHK("write executed", 1, dn - c)
  endtask : dwr

  function automatic logic [31:0] exp_w(input logic [4:0] inc);
    logic [31:0] w;
    int          p;
    w = {res, 18'h0};
    p = 18;
    if (inc[4]) begin p -= 4; w[p+:4] = 4'hA; end
    if (inc[3]) begin p -= 2; w[p+:2] = sa; end
    if (inc[2]) begin p -= 2; w[p+:2] = ia; end
    if (inc[1]) begin p -= 4; w[p+:4] = rg; end
    if (inc[0]) begin p -= 2; w[p+:2] = {^res, ^{res, 4'hA, sa, ia, rg}}; end
    return w;
  endfunction : exp_w

  task automatic s_format;
    logic [31:0] g;
    logic [4:0]  inc;
    dwr(9'h002, 16'h000A);
    for (int i = 0; i < 3; i++)
    begin
      inc = (i == 0) ? 5'h1F : (i == 1) ? 5'h0B : 5'h00;
      dwr(9'h010, {3'h0, inc, 8'h00});
      frame(32'h0, g);
      `CHK("result word", exp_w(inc), g)
    end
  endtask : s_format

  task automatic s_reads;
    logic [31:0] g;
    dwr(9'h010, 16'h1F03);
    frame({5'h19, 2'h0, 9'h010, 16'h0}, g);
    `CHK("pattern bit clear", exp_w(5'h1F), g)
    frame({5'h09, 2'h0, 9'h011, 16'h0}, g);
    `CHK("halfword read", {16'h1F03, 16'h0}, g)
    frame({5'h19, 2'h0, 9'h003, 16'h0}, g);
    `CHK("byte read", {8'h1F, 24'h0}, g)
    frame(32'h0, g);
    `CHK("chain id read", {16'h000A, 16'h0}, g)
    frame(32'h0, g);
    `CHK("back to result", exp_w(5'h1F), g)
  endtask : s_reads

  task automatic s_pattern;
    logic [31:0] g;
    logic [31:0] pat;
    for (int i = 0; i < 4; i++)
    begin
      pat = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF :
            (i == 2) ? 32'hAAAAAAAA : 32'hCCCCCCCC;
      dwr(9'h010, {8'h1F, 6'h01, 2'(i)});
      frame(32'h0, g);
      `CHK("fixed pattern", pat, g)
    end
    dwr(9'h010, 16'h0);
  endtask : s_pattern

  task automatic s_short;
    logic [31:0] g;
    logic [31:0] e;
    int          c;
    e = exp_w(5'h00);
    bus(1'b1, 2'h1, 32'h0000000C);
    frame(32'h0, g);
    `CHK("short frame bits", e[31:20], g[11:0])
    c = dn;
    frame({5'h1A, 2'h0, 9'h010, 16'h0004}, g);
    `CHK("short write dropped", 0, dn - c)
    bus(1'b1, 2'h1, 32'h00000020);
    frame(32'h0, g);
    `CHK("no pattern after short", e, g)
    bus(1'b1, 2'h1, 32'h00000028);
    frame(32'hA5000000, g);
    `CHK("chain fill", {e[23:0], 8'hA5}, g)
    bus(1'b1, 2'h1, 32'h00000020);
  endtask : s_short

  task automatic s_proto;
    logic [31:0] g;
    for (int m = 1; m < 4; m++)
    begin
      dwr(9'h008, 16'(m));
      `CHK("protocol", 2'(m), proto)
      bus(1'b1, 2'h1, {22'h0, 2'(m), 8'h20});
      @(posedge clk);
      res <= 14'h1234 + 14'(m);
      frame(32'h0, g);
      frame(32'h0, g);
      `CHK("word in new mode", exp_w(5'h00), g)
      dwr(9'h008, 16'h0);
      bus(1'b1, 2'h1, 32'h00000020);
      `CHK("protocol back", 2'h0, proto)
    end
  endtask : s_proto

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("protocol after reset", 2'h0, proto)
    s_format();
    s_reads();
    s_pattern();
    s_short();
    s_proto();
    test_done();
  end
endmodule : adc_serial_output_word_and_protocol_bench
`default_nettype wire
